// ===== core/twi_slave_pkg.sv
package twi_slave_pkg;
  localparam logic [6:0] own_address = 7'h2c;
  localparam logic [7:0] write_first_byte = 8'h58;
  localparam logic [7:0] read_first_byte = 8'h59;
  localparam int bits_per_byte = 8;
  localparam logic [7:0] pointer_reset = 8'h00;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_addr = 3'b001,
    st_addr_ack = 3'b011,
    st_rx = 3'b010,
    st_rx_ack = 3'b110,
    st_tx = 3'b111,
    st_tx_ack = 3'b101
  } slave_state_t;

  typedef struct packed {
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } reg_write_t;
endpackage

// ===== core/twi_slave.sv
`timescale 1ns/1ns
// Overview of operation
// - Answer only to seven-bit address 2Ch; first byte 58h write, 59h read.
// - First seven bits after start are compared with own address.
// - Eighth bit selects direction: one reads, zero writes.
// - Matching address is acknowledged in the ninth clock.
// - First written byte loads the register pointer and is acknowledged.
// - Later written bytes go to the pointed register and are acknowledged.
// - Pointer advances by one after each written data byte.
// - After read address ack, pointed register is sent MSB first.
// - Master ack advances pointer and next register is sent.
// - Master nack then stop ends read; device releases data line.
// - Every byte is eight bits MSB first plus an ack slot.
// - Data change while clock high mid-transfer abandons the transfer.
module twi_slave
  import twi_slave_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output reg_write_t reg_wr,
  output logic [7:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data
);

  // ----------------------------------------
  // Pin synchronisers and condition detect
  // ----------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_d;
  logic sda_d;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  wire scl_rise = scl_sync[1] & ~scl_d;
  wire scl_fall = ~scl_sync[1] & scl_d;
  wire start_cond = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  wire stop_cond = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

  // ----------------------------------------
  // Byte engine
  // ----------------------------------------
  slave_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [7:0] pointer;
  logic pointer_loaded;
  logic master_ack;

  // Upper seven bits are the address, bit 0 the direction, so 58h and 59h both match
  wire addr_match = (shift_in[7:1] == own_address);
  // Bits counted on rises, so the fall that follows a start is not taken as a bit
  wire last_bit = (bit_cnt == 4'(bits_per_byte));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= st_idle;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      pointer_loaded <= 1'b0;
      master_ack <= 1'b0;
    // Any data change with clock high is a start or a stop; both abandon a byte
    end else if (start_cond) begin
      state <= st_addr;
      bit_cnt <= 4'h0;
      pointer_loaded <= 1'b0;
    end else if (stop_cond) begin
      state <= st_idle;
    end else begin
      unique case (state)
        st_idle: begin
        end
        st_addr, st_rx: begin
          if (scl_rise) begin
            shift_in <= {shift_in[6:0], sda_sync[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (scl_fall && last_bit) begin
            bit_cnt <= 4'h0;
            if (state == st_rx) begin
              state <= st_rx_ack;
            end else if (addr_match) begin
              state <= st_addr_ack;
            end else begin
              state <= st_idle;
            end
          end
        end
        st_addr_ack: begin
          if (scl_fall) begin
            state <= shift_in[0] ? st_tx : st_rx;
          end
        end
        st_rx_ack: begin
          if (scl_fall) begin
            pointer_loaded <= 1'b1;
            state <= st_rx;
          end
        end
        st_tx: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (scl_fall && last_bit) begin
            bit_cnt <= 4'h0;
            state <= st_tx_ack;
          end
        end
        st_tx_ack: begin
          if (scl_rise) begin
            master_ack <= ~sda_sync[1];
          end
          if (scl_fall) begin
            state <= master_ack ? st_tx : st_idle;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Register pointer and writes
  // ----------------------------------------
  wire rx_ack_done = (state == st_rx_ack) && scl_fall && !start_cond && !stop_cond;
  wire tx_ack_done = (state == st_tx_ack) && scl_fall && master_ack
    && !start_cond && !stop_cond;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pointer <= pointer_reset;
    end else if (rx_ack_done && !pointer_loaded) begin
      pointer <= shift_in;
    end else if (rx_ack_done || tx_ack_done) begin
      pointer <= pointer + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_wr <= '0;
    end else begin
      // Strobe once per data byte, one cycle after ack slot end, carrying the pointer value from before its step
      reg_wr.wr_en <= rx_ack_done && pointer_loaded;
      reg_wr.wr_addr <= pointer;
      reg_wr.wr_data <= shift_in;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rd_addr <= pointer_reset;
    end else begin
      reg_rd_addr <= pointer;
    end
  end

  // ----------------------------------------
  // Data line drive
  // ----------------------------------------
  // Reload until the first rise of a byte: read data lags a pointer step two cycles,
  // so the byte after a master ack must not be frozen at the opening fall
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shift_out <= 8'hff;
    end else if ((state == st_tx) && scl_fall && !last_bit) begin
      shift_out <= {shift_out[6:0], 1'b1};
    end else if ((state != st_tx) || (bit_cnt == 4'h0)) begin
      shift_out <= reg_rd_data;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sda_oe_n <= 1'b1;
      sda_out <= 1'b1;
    end else begin
      sda_out <= 1'b0;
      unique case (state)
        st_addr_ack, st_rx_ack: sda_oe_n <= 1'b0;
        st_tx: sda_oe_n <= shift_out[7];
        default: sda_oe_n <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_nack_foreign: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == st_addr && scl_fall && last_bit && !addr_match && !start_cond && !stop_cond
     && !(scl_sync[1] && scl_d && sda_sync[1] != sda_d)) |=> state == st_idle)
    else $error("foreign address not ignored");
  chk_ack_own: assert property (@(posedge clk_sys) disable iff (!nrst)
    state == st_addr_ack |=> !sda_oe_n)
    else $error("own address not acknowledged");
  chk_start_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
    start_cond |=> state == st_addr && bit_cnt == 4'h0)
    else $error("start does not restart address phase");
  chk_stop_release: assert property (@(posedge clk_sys) disable iff (!nrst)
    stop_cond |=> ##1 sda_oe_n)
    else $error("line not released after stop");
  chk_glitch_abort: assert property (@(posedge clk_sys) disable iff (!nrst)
    (scl_sync[1] && scl_d && sda_sync[1] != sda_d) |=> state inside {st_idle, st_addr})
    else $error("transfer not abandoned");
  chk_write_strobe: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rx_ack_done && pointer_loaded) |=> reg_wr.wr_en && reg_wr.wr_addr == $past(pointer))
    else $error("write strobe missing");
  chk_ptr_advance: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rx_ack_done && pointer_loaded) |=> pointer == $past(pointer) + 8'h01)
    else $error("pointer not advanced");
  chk_read_dir: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == st_addr_ack && scl_fall && !start_cond && !stop_cond && shift_in[0])
    |=> state == st_tx)
    else $error("read bit did not select transmit");
  chk_tx_advance: assert property (@(posedge clk_sys) disable iff (!nrst)
    tx_ack_done |=> pointer == $past(pointer) + 8'h01)
    else $error("read pointer not advanced");
  cov_write: cover property (@(posedge clk_sys) disable iff (!nrst) reg_wr.wr_en);
  cov_read: cover property (@(posedge clk_sys) disable iff (!nrst) tx_ack_done);
  cov_nack_end: cover property (@(posedge clk_sys) disable iff (!nrst)
    state == st_tx_ack ##1 state == st_idle);
  cov_foreign: cover property (@(posedge clk_sys) disable iff (!nrst)
    state == st_addr ##1 state == st_idle);

endmodule

// ===== tb/twi_master_model.sv
`timescale 1ns/1ns
// ------------------------------
// Bus master model
// ------------------------------
// Line is pulled up unless a party pulls it low; SCL stands high between frames
module twi_master_model (
  input wire logic clk_sys,
  input wire logic sda_oe_n,
  input wire logic sda_out,
  output logic scl,
  output logic sda
);
  logic sda_drv = 1'b1;
  initial scl = 1'b1;
  assign sda = sda_drv & (sda_oe_n | sda_out);

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Halves of ten cycles keep well above the slave's eight-cycle minimum
  task automatic start();
    sda_drv = 1'b1;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_drv = 1'b0;
    tick(10);
    scl = 1'b0;
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_drv = 1'b1;
    tick(10);
  endtask

  task automatic clk_bit(input logic b, output logic s);
    sda_drv = b;
    tick(10);
    scl = 1'b1;
    tick(10);
    s = sda;
    scl = 1'b0;
  endtask

  task automatic send(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv(input logic mack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      v[i] = s;
    end
    clk_bit(~mack, s);
  endtask
endmodule

// ===== tb/i2c_slave_register_access_tb.sv
`timescale 1ns/1ns
module i2c_slave_register_access_tb;
  import twi_slave_pkg::*;
  typedef struct {logic [7:0] first, ptr, data; logic ack; logic [7:0] exp;} row_t;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic scl, sda, sda_out, sda_oe_n, ack;
  reg_write_t reg_wr;
  logic [7:0] reg_rd_addr, rd, v;
  logic [7:0] regs [256];
  int n_fail = 0;
  int num_checks = 0;
  row_t rows [5] = '{'{8'h58, 8'h10, 8'ha5, 1'b1, 8'ha5}, '{8'h5a, 8'h11, 8'h3c, 1'b0, 8'h11},
    '{8'hd8, 8'h12, 8'h77, 1'b0, 8'h12}, '{8'h58, 8'hff, 8'h81, 1'b1, 8'h81},
    '{8'h58, 8'h00, 8'hfe, 1'b1, 8'hfe}};

  always #20 clk_sys = ~clk_sys;
  assign rd = regs[reg_rd_addr];
  // Register file refilled during reset so one process alone writes it
  always @(posedge clk_sys) begin
    if (!nrst) begin
      for (int i = 0; i < 256; i++) regs[i] <= i[7:0];
    end else if (reg_wr.wr_en) begin
      regs[reg_wr.wr_addr] <= reg_wr.wr_data;
    end
  end

  twi_master_model u_master (.clk_sys(clk_sys), .sda_oe_n(sda_oe_n), .sda_out(sda_out),
    .scl(scl), .sda(sda));
  twi_slave u_dut (.clk_sys(clk_sys), .nrst(nrst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(rd));

  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic sendc(input logic [7:0] b, input logic exp);
    u_master.send(b, ack);
    check({7'h00, ack}, {7'h00, exp});
  endtask

  task automatic summarize();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    u_master.tick(6);
    nrst = 1'b1;
    u_master.tick(4);
    check({7'h00, sda_oe_n}, 8'h01);
    for (int i = 0; i < 5; i++) begin
      u_master.start();
      sendc(rows[i].first, rows[i].ack);
      sendc(rows[i].ptr, rows[i].ack);
      sendc(rows[i].data, rows[i].ack);
      u_master.stop();
      check(regs[rows[i].ptr], rows[i].exp);
    end
    // Burst write then combined read of the same three places
    u_master.start();
    sendc(8'h58, 1'b1);
    sendc(8'h20, 1'b1);
    for (int i = 1; i <= 3; i++) sendc(8'h11 * i, 1'b1);
    u_master.stop();
    check(regs[8'h23], 8'h23);
    check(regs[8'h22], 8'h33);
    u_master.start();
    sendc(8'h58, 1'b1);
    sendc(8'h20, 1'b1);
    u_master.start();
    sendc(read_first_byte, 1'b1);
    for (int i = 1; i <= 3; i++) begin
      u_master.recv(i < 3, v);
      check(v, 8'h11 * i);
    end
    u_master.stop();
    check({7'h00, sda_oe_n}, 8'h01);
    // Stop in mid byte, then bytes without a start are ignored
    u_master.start();
    sendc(8'h58, 1'b1);
    sendc(8'h30, 1'b1);
    for (int i = 0; i < 4; i++) u_master.clk_bit(1'b0, ack);
    u_master.stop();
    sendc(8'h58, 1'b0);
    check(regs[8'h30], 8'h30);
    // Foreign address, then repeated start to our own
    u_master.start();
    sendc(8'h5a, 1'b0);
    u_master.start();
    sendc(8'h58, 1'b1);
    sendc(8'h40, 1'b1);
    sendc(8'h44, 1'b1);
    u_master.stop();
    check(regs[8'h40], 8'h44);
    // Reset in mid run drops the pointer and releases the line
    nrst = 1'b0;
    u_master.tick(6);
    check(reg_rd_addr, pointer_reset);
    check({7'h00, sda_oe_n}, 8'h01);
    check({7'h00, sda_out}, 8'h01);
    nrst = 1'b1;
    u_master.tick(4);
    check({7'h00, sda_out}, 8'h00);
    check({7'h00, sda_oe_n}, 8'h01);
    // Port works again after the second release
    u_master.start();
    sendc(8'h58, 1'b1);
    sendc(8'h50, 1'b1);
    sendc(8'h5a, 1'b1);
    u_master.stop();
    check(regs[8'h50], 8'h5a);
    summarize();
  end

  initial begin
    #2000000;
    n_fail++;
    summarize();
  end
endmodule
